/* File: rtl/eimc_pkg.sv */
// Constants for the extended interrupt mask and comparator 1 control block.
// Assumes an 8-bit special-function-register bus with 8-bit addresses.
package eimc_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] EIMC_ADDR_CMP1_CTRL = 8'hBF;
    localparam logic [7:0] EIMC_ADDR_IRQ_MASK  = 8'hE6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] EIMC_RST_CMP1_CTRL  = 8'h00;
    localparam logic [7:0] EIMC_RST_IRQ_MASK   = 8'h00;
    localparam logic [7:0] EIMC_RDATA_NONE     = 8'h00;

    // ------------------------------------------------------------
    // Mask register bit positions
    // ------------------------------------------------------------
    localparam int EIMC_MSK_TIMER   = 7;
    localparam int EIMC_MSK_CMP1    = 6;
    localparam int EIMC_MSK_CMP0    = 5;
    localparam int EIMC_MSK_PCA     = 4;
    localparam int EIMC_MSK_ADC     = 3;
    localparam int EIMC_MSK_WINDOW  = 2;
    localparam int EIMC_MSK_MATCH   = 1;
    localparam int EIMC_MSK_TWOWIRE = 0;

    // ------------------------------------------------------------
    // Comparator 1 control bit positions
    // ------------------------------------------------------------
    localparam int EIMC_CMP_ON      = 7;
    localparam int EIMC_CMP_OUT     = 6;
    localparam int EIMC_CMP_RISE    = 5;
    localparam int EIMC_CMP_FALL    = 4;
    localparam int EIMC_CMP_HYP_HI  = 3;
    localparam int EIMC_CMP_HYP_LO  = 2;
    localparam int EIMC_CMP_HYN_HI  = 1;
    localparam int EIMC_CMP_HYN_LO  = 0;

    // ------------------------------------------------------------
    // Hysteresis select codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        EIMC_HYST_OFF  = 2'h0,
        EIMC_HYST_5MV  = 2'h1,
        EIMC_HYST_10MV = 2'h2,
        EIMC_HYST_20MV = 2'h3
    } eimc_hyst_e;

endpackage

/* File: rtl/eimc_cmp1_ctrl.sv */
// Comparator 1 control register: enable, output state, sticky edge flags,
// hysteresis selects. Assumes the comparator result arrives asynchronously.
`timescale 1ns/1ps
module eimc_cmp1_ctrl
    import eimc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_cmp_raw,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_ctrl,
    output logic            o_on,
    output logic            o_rise,
    output logic            o_fall,
    output eimc_hyst_e      o_hyp,
    output eimc_hyst_e      o_hyn
);

    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic rise_evt;
    logic fall_evt;

    // ------------------------------------------------------------
    // Synchroniser and edge detection
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end else begin
            sync1_r <= i_cmp_raw;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // A disabled comparator reads low, so edges are taken only while it runs
    assign rise_evt = o_on & sync2_r & ~prev_r;
    assign fall_evt = o_on & ~sync2_r & prev_r;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_on  <= EIMC_RST_CMP1_CTRL[EIMC_CMP_ON];
            o_hyp <= eimc_hyst_e'(EIMC_RST_CMP1_CTRL[EIMC_CMP_HYP_HI:EIMC_CMP_HYP_LO]);
            o_hyn <= eimc_hyst_e'(EIMC_RST_CMP1_CTRL[EIMC_CMP_HYN_HI:EIMC_CMP_HYN_LO]);
        end else if (i_wr_en) begin
            o_on  <= i_wdata[EIMC_CMP_ON];
            o_hyp <= eimc_hyst_e'(i_wdata[EIMC_CMP_HYP_HI:EIMC_CMP_HYP_LO]);
            o_hyn <= eimc_hyst_e'(i_wdata[EIMC_CMP_HYN_HI:EIMC_CMP_HYN_LO]);
        end
    end

    // ------------------------------------------------------------
    // Sticky edge flags; an edge in the clearing cycle wins
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rise <= EIMC_RST_CMP1_CTRL[EIMC_CMP_RISE];
        end else if (rise_evt) begin
            o_rise <= 1'b1;
        end else if (i_wr_en) begin
            o_rise <= i_wdata[EIMC_CMP_RISE];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_fall <= EIMC_RST_CMP1_CTRL[EIMC_CMP_FALL];
        end else if (fall_evt) begin
            o_fall <= 1'b1;
        end else if (i_wr_en) begin
            o_fall <= i_wdata[EIMC_CMP_FALL];
        end
    end

    // Output state is read-only; writes to it are dropped
    always_comb begin
        o_ctrl                                  = EIMC_RST_CMP1_CTRL;
        o_ctrl[EIMC_CMP_ON]                     = o_on;
        o_ctrl[EIMC_CMP_OUT]                    = o_on & sync2_r;
        o_ctrl[EIMC_CMP_RISE]                   = o_rise;
        o_ctrl[EIMC_CMP_FALL]                   = o_fall;
        o_ctrl[EIMC_CMP_HYP_HI:EIMC_CMP_HYP_LO] = o_hyp;
        o_ctrl[EIMC_CMP_HYN_HI:EIMC_CMP_HYN_LO] = o_hyn;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_RISE_SETS: assert property (@(posedge i_clk) disable iff (!i_resetn)
        rise_evt |=> o_rise)
        else $error("rising edge did not set the rising flag");

    AST_RISE_HOLDS: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_rise && !i_wr_en) |=> o_rise)
        else $error("rising flag cleared without a write");

    AST_FALL_SETS: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_on && prev_r && !sync2_r) |=> o_fall)
        else $error("falling edge did not set the falling flag");

    AST_FALL_CLEAR: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_wr_en && !i_wdata[EIMC_CMP_FALL] && !fall_evt) |=> !o_fall)
        else $error("software clear of falling flag ignored");

    AST_ON_WRITE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_wr_en |=> (o_on == $past(i_wdata[EIMC_CMP_ON])))
        else $error("enable bit did not follow the write");

    AST_OUT_STATE: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_on && $past(o_on, 3)) |-> (o_ctrl[EIMC_CMP_OUT] == $past(i_cmp_raw, 2)))
        else $error("output state does not track comparator");

endmodule

/* File: rtl/eimc_top.sv */
// Extended interrupt mask and comparator 1 control, reached over the
// special-function-register bus. Flags other than comparator 1 come from
// logic on the same clock; the comparator 1 result is asynchronous.
//
// Contract
// - Mask bit 7 gates both timer overflow flags onto the timer request.
// - Mask bit 6 gates comparator 1 rising or falling flag onto its request.
// - Mask bit 5 gates comparator 0 rising or falling flag onto its request.
// - Mask bit 4 gates every counter array request.
// - Mask bit 3 gates the conversion-done flag.
// - Mask bit 2 gates the window-compare flag.
// - Mask bit 1 gates port-match requests.
// - Comparator control bit 7 switches comparator 1 on or off.
// - Control bit 6 is read-only comparator output, low when plus below minus.
// - Bit 5 sets on rising edge, stays until software writes zero.
// - Bit 4 sets on falling edge, stays until software writes zero.
// - Bits 3:2 positive hysteresis: off, 5, 10, 20 mV.
// - Bits 1:0 negative hysteresis: off, 5, 10, 20 mV.
`timescale 1ns/1ps
module eimc_top
    import eimc_pkg::*;
(
    input  wire logic       I_CLK,
    input  wire logic       I_RESETN,
    input  wire logic [7:0] I_SFR_ADDR,
    input  wire logic [7:0] I_SFR_WDATA,
    input  wire logic       I_SFR_WE,
    input  wire logic       I_SFR_RE,
    input  wire logic       I_TIMER_LOW_OVF,
    input  wire logic       I_TIMER_HIGH_OVF,
    input  wire logic       I_CMP0_RISE_FLAG,
    input  wire logic       I_CMP0_FALL_FLAG,
    input  wire logic       I_PCA_REQ,
    input  wire logic       I_CONV_DONE_FLAG,
    input  wire logic       I_WINDOW_FLAG,
    input  wire logic       I_PORT_MATCH,
    input  wire logic       I_CMP1_RAW,
    output logic      [7:0] O_SFR_RDATA,
    output logic            O_SFR_RVALID,
    output logic            O_TIMER_IRQ,
    output logic            O_CMP1_IRQ,
    output logic            O_CMP0_IRQ,
    output logic            O_PCA_IRQ,
    output logic            O_CONV_DONE_IRQ,
    output logic            O_WINDOW_IRQ,
    output logic            O_PORT_MATCH_IRQ,
    output logic            O_CMP1_ON,
    output logic      [1:0] O_CMP1_HYP,
    output logic      [1:0] O_CMP1_HYN
);

    logic [7:0] irq_mask_r;
    logic [7:0] cmp_ctrl;
    logic       cmp_on;
    logic       cmp_rise;
    logic       cmp_fall;
    eimc_hyst_e cmp_hyp;
    eimc_hyst_e cmp_hyn;
    logic       wr_mask;
    logic       wr_cmp;
    logic [7:0] rdata_nxt;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    assign wr_mask = I_SFR_WE & (I_SFR_ADDR == EIMC_ADDR_IRQ_MASK);
    assign wr_cmp  = I_SFR_WE & (I_SFR_ADDR == EIMC_ADDR_CMP1_CTRL);

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            irq_mask_r <= EIMC_RST_IRQ_MASK;
        end else if (wr_mask) begin
            irq_mask_r <= I_SFR_WDATA;
        end
    end

    // Unmapped addresses read zero so the core sees a defined value
    always_comb begin
        case (I_SFR_ADDR)
            EIMC_ADDR_IRQ_MASK:  rdata_nxt = irq_mask_r;
            EIMC_ADDR_CMP1_CTRL: rdata_nxt = cmp_ctrl;
            default:             rdata_nxt = EIMC_RDATA_NONE;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            O_SFR_RDATA  <= EIMC_RDATA_NONE;
            O_SFR_RVALID <= 1'b0;
        end else begin
            O_SFR_RVALID <= I_SFR_RE;
            if (I_SFR_RE) begin
                O_SFR_RDATA <= rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // Comparator 1 control
    // ------------------------------------------------------------
    eimc_cmp1_ctrl u_cmp1 (
        .i_clk    (I_CLK),
        .i_resetn (I_RESETN),
        .i_cmp_raw(I_CMP1_RAW),
        .i_wr_en  (wr_cmp),
        .i_wdata  (I_SFR_WDATA),
        .o_ctrl   (cmp_ctrl),
        .o_on     (cmp_on),
        .o_rise   (cmp_rise),
        .o_fall   (cmp_fall),
        .o_hyp    (cmp_hyp),
        .o_hyn    (cmp_hyn)
    );

    // Mirrors add one cycle so every top output leaves a flip-flop
    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            O_CMP1_ON  <= EIMC_RST_CMP1_CTRL[EIMC_CMP_ON];
            O_CMP1_HYP <= EIMC_RST_CMP1_CTRL[EIMC_CMP_HYP_HI:EIMC_CMP_HYP_LO];
            O_CMP1_HYN <= EIMC_RST_CMP1_CTRL[EIMC_CMP_HYN_HI:EIMC_CMP_HYN_LO];
        end else begin
            O_CMP1_ON  <= cmp_on;
            O_CMP1_HYP <= cmp_hyp;
            O_CMP1_HYN <= cmp_hyn;
        end
    end

    // ------------------------------------------------------------
    // Request gating, re-evaluated every clock
    // ------------------------------------------------------------
    // The core owns flag clearing, so a request drops one cycle after its
    // mask bit or its last pending flag drops.
    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            O_TIMER_IRQ      <= 1'b0;
            O_CMP1_IRQ       <= 1'b0;
            O_CMP0_IRQ       <= 1'b0;
            O_PCA_IRQ        <= 1'b0;
            O_CONV_DONE_IRQ  <= 1'b0;
            O_WINDOW_IRQ     <= 1'b0;
            O_PORT_MATCH_IRQ <= 1'b0;
        end else begin
            O_TIMER_IRQ      <= irq_mask_r[EIMC_MSK_TIMER]
                                & (I_TIMER_LOW_OVF | I_TIMER_HIGH_OVF);
            O_CMP1_IRQ       <= irq_mask_r[EIMC_MSK_CMP1]
                                & (cmp_rise | cmp_fall);
            O_CMP0_IRQ       <= irq_mask_r[EIMC_MSK_CMP0]
                                & (I_CMP0_RISE_FLAG | I_CMP0_FALL_FLAG);
            O_PCA_IRQ        <= irq_mask_r[EIMC_MSK_PCA] & I_PCA_REQ;
            O_CONV_DONE_IRQ  <= irq_mask_r[EIMC_MSK_ADC] & I_CONV_DONE_FLAG;
            O_WINDOW_IRQ     <= irq_mask_r[EIMC_MSK_WINDOW] & I_WINDOW_FLAG;
            O_PORT_MATCH_IRQ <= irq_mask_r[EIMC_MSK_MATCH] & I_PORT_MATCH;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_mask_write(int bitpos, logic val);
        wr_mask && (I_SFR_WDATA[bitpos] == val);
    endsequence

    AST_TIMER_GATE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        O_TIMER_IRQ == $past(irq_mask_r[EIMC_MSK_TIMER]
                             & (I_TIMER_LOW_OVF | I_TIMER_HIGH_OVF)))
        else $error("timer request not gated by mask bit 7");

    AST_CMP1_BLOCK: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        s_mask_write(EIMC_MSK_CMP1, 1'b0) ##1 !wr_mask |=> !O_CMP1_IRQ)
        else $error("comparator 1 request passed while masked");

    AST_CMP1_PASS: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (irq_mask_r[EIMC_MSK_CMP1] && (cmp_rise || cmp_fall)) |=> O_CMP1_IRQ)
        else $error("comparator 1 request missing");

    AST_CMP0_GATE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        O_CMP0_IRQ |-> $past(irq_mask_r[EIMC_MSK_CMP0])
                       && $past(I_CMP0_RISE_FLAG || I_CMP0_FALL_FLAG))
        else $error("comparator 0 request without cause");

    AST_PCA_GATE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        O_PCA_IRQ == $past(irq_mask_r[EIMC_MSK_PCA] && I_PCA_REQ))
        else $error("counter array request not gated by mask bit 4");

    AST_CONV_GATE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        s_mask_write(EIMC_MSK_ADC, 1'b1) ##1 (I_CONV_DONE_FLAG && !wr_mask)
        |=> O_CONV_DONE_IRQ)
        else $error("conversion-done request missing after enable");

    AST_WINDOW_GATE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        O_WINDOW_IRQ == $past(irq_mask_r[EIMC_MSK_WINDOW] && I_WINDOW_FLAG))
        else $error("window request not gated by mask bit 2");

    AST_MATCH_GATE: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (!irq_mask_r[EIMC_MSK_MATCH]) |=> !O_PORT_MATCH_IRQ)
        else $error("port-match request passed while masked");

    AST_MASK_READ: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (I_SFR_RE && I_SFR_ADDR == EIMC_ADDR_IRQ_MASK && !I_SFR_WE)
        |=> O_SFR_RVALID && (O_SFR_RDATA == irq_mask_r))
        else $error("mask readback wrong");

    AST_HYST_MIRROR: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        wr_cmp |=> ##1 (O_CMP1_HYP == $past(I_SFR_WDATA[EIMC_CMP_HYP_HI:EIMC_CMP_HYP_LO], 2))
                   && (O_CMP1_HYN == $past(I_SFR_WDATA[EIMC_CMP_HYN_HI:EIMC_CMP_HYN_LO], 2)))
        else $error("hysteresis outputs do not follow the write");

    // Either overflow flag alone must be enough to raise the timer request
    AST_TIMER_PASS: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (irq_mask_r[EIMC_MSK_TIMER] && (I_TIMER_LOW_OVF || I_TIMER_HIGH_OVF))
        |=> O_TIMER_IRQ)
        else $error("timer request missing while enabled");

    AST_CMP1_ON_MIRROR: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        O_CMP1_ON == $past(cmp_on))
        else $error("comparator enable output does not follow the control bit");

    // A switched-off comparator must never report a high output state
    AST_OFF_READS_LOW: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (I_SFR_RE && (I_SFR_ADDR == EIMC_ADDR_CMP1_CTRL) && !cmp_on)
        |=> !O_SFR_RDATA[EIMC_CMP_OUT])
        else $error("output state read high while comparator off");

    AST_MASKED_QUIET: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (irq_mask_r == 8'h00)
        |=> !(O_TIMER_IRQ || O_CMP1_IRQ || O_CMP0_IRQ || O_PCA_IRQ
              || O_CONV_DONE_IRQ || O_WINDOW_IRQ || O_PORT_MATCH_IRQ))
        else $error("request raised with every mask bit clear");

endmodule

/* File: verification/eimc_core_model.sv */
// Core-side model: issues register accesses on the special-function-register
// bus. Assumes the bench calls its tasks and that there is one rising-edge clock.
`timescale 1ns/1ps
module eimc_core_model
(
    input  wire logic       i_clk,
    input  wire logic       i_rvalid,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_we,
    output logic            o_re
);
    initial begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_we    = 1'b0;
        o_re    = 1'b0;
    end

    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Software clears a sticky edge flag only by writing zero here
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_addr  = a;
        o_wdata = d;
        o_we    = 1'b1;
        @(posedge i_clk);
        #1;
        o_we    = 1'b0;
        // Released lines must not keep showing the last value
        o_addr  = ~a;
        o_wdata = ~d;
    endtask

    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_re   = 1'b1;
        @(posedge i_clk);
        #1;
        o_re   = 1'b0;
        o_addr = ~a;
        v      = i_rvalid;
        d      = i_rdata;
    endtask
endmodule

/* File: verification/test_ext_irq_mask_cmp_edge_flags.sv */
// Self-checking bench for the interrupt mask and comparator 1 control block.
// Assumes the core model drives the register bus; the bench drives the flags.
`timescale 1ns/1ps
module test_ext_irq_mask_cmp_edge_flags;
    import eimc_pkg::*;

    logic       i_clk    = 1'b0;
    logic       i_resetn = 1'b0;
    logic       cmp_raw  = 1'b0;
    logic [7:0] src      = 8'h00;
    wire  [7:0] addr;
    wire  [7:0] wdata;
    wire  [7:0] rdata;
    wire  [1:0] hyp;
    wire  [1:0] hyn;
    wire        we;
    wire        re;
    wire        rvalid;
    wire        cmp_on;
    wire  [7:0] irq_seen;
    wire  [6:0] irq;
    int         mismatches = 0;
    int         checks     = 0;

    // Request outputs lined up with the mask bits that gate them
    assign irq_seen = {irq, 1'b0};

    always #4 i_clk = ~i_clk;

    eimc_core_model i_core (.i_clk(i_clk), .i_rvalid(rvalid), .i_rdata(rdata),
        .o_addr(addr), .o_wdata(wdata), .o_we(we), .o_re(re));

    eimc_top i_dut (
        .I_CLK(i_clk), .I_RESETN(i_resetn), .I_SFR_ADDR(addr), .I_SFR_WDATA(wdata),
        .I_SFR_WE(we), .I_SFR_RE(re), .I_TIMER_LOW_OVF(src[0]), .I_TIMER_HIGH_OVF(src[1]),
        .I_CMP0_RISE_FLAG(src[2]), .I_CMP0_FALL_FLAG(src[3]), .I_PCA_REQ(src[4]),
        .I_CONV_DONE_FLAG(src[5]), .I_WINDOW_FLAG(src[6]), .I_PORT_MATCH(src[7]),
        .I_CMP1_RAW(cmp_raw), .O_SFR_RDATA(rdata), .O_SFR_RVALID(rvalid),
        .O_TIMER_IRQ(irq[6]), .O_CMP1_IRQ(irq[5]), .O_CMP0_IRQ(irq[4]), .O_PCA_IRQ(irq[3]),
        .O_CONV_DONE_IRQ(irq[2]), .O_WINDOW_IRQ(irq[1]), .O_PORT_MATCH_IRQ(irq[0]),
        .O_CMP1_ON(cmp_on), .O_CMP1_HYP(hyp), .O_CMP1_HYN(hyn));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        i_core.sfr_read(a, d, v);
        check({name, " rvalid"}, {7'h00, v}, 8'h01);
        check(name, d, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // Expected requests: one bit per mask position, source flags ORed
    function automatic logic [7:0] exp_irq(logic [7:0] m, logic [7:0] s, logic c1);
        logic [7:0] e;
        e    = 8'h00;
        e[7] = m[7] & (s[0] | s[1]);
        e[6] = m[6] & c1;
        e[5] = m[5] & (s[2] | s[3]);
        e[4] = m[4] & s[4];
        e[3] = m[3] & s[5];
        e[2] = m[2] & s[6];
        e[1] = m[1] & s[7];
        return e;
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        check("irq after reset", irq_seen, 8'h00);
        check("on after reset", {7'h00, cmp_on}, 8'h00);
        rd_check("mask reset", EIMC_ADDR_IRQ_MASK, EIMC_RST_IRQ_MASK);
        rd_check("cmp reset", EIMC_ADDR_CMP1_CTRL, EIMC_RST_CMP1_CTRL);
        i_core.sfr_write(8'h55, 8'hFF);
        rd_check("unmapped read", 8'h55, EIMC_RDATA_NONE);
        rd_check("mask after stray write", EIMC_ADDR_IRQ_MASK, 8'h00);
    endtask

    task automatic test_masks();
        logic [7:0] s;
        logic [7:0] own;
        int         pos [8] = '{7, 7, 5, 5, 4, 3, 2, 1};
        for (int k = 0; k < 8; k++) begin
            s   = 8'h01 << k;
            own = 8'h01 << pos[k];
            src = s;
            i_core.sfr_write(EIMC_ADDR_IRQ_MASK, 8'h00);
            wait_cyc(3);
            check("irq masked", irq_seen, 8'h00);
            i_core.sfr_write(EIMC_ADDR_IRQ_MASK, ~own);
            wait_cyc(3);
            check("irq other masks", irq_seen, exp_irq(~own, s, 1'b0));
            i_core.sfr_write(EIMC_ADDR_IRQ_MASK, own);
            wait_cyc(3);
            check("irq enabled", irq_seen, own);
        end
        i_core.sfr_write(EIMC_ADDR_IRQ_MASK, 8'hFF);
        src = 8'h00;
        wait_cyc(3);
        check("irq flags gone", irq_seen, 8'h00);
        rd_check("mask readback", EIMC_ADDR_IRQ_MASK, 8'hFF);
    endtask

    task automatic test_cmp();
        i_core.sfr_write(EIMC_ADDR_IRQ_MASK, 8'h40);
        i_core.sfr_write(EIMC_ADDR_CMP1_CTRL, 8'h80);
        wait_cyc(3);
        check("cmp on", {7'h00, cmp_on}, 8'h01);
        cmp_raw = 1'b1;
        wait_cyc(6);
        rd_check("rising flag", EIMC_ADDR_CMP1_CTRL, 8'hE0);
        check("cmp1 irq", irq_seen, 8'h40);
        cmp_raw = 1'b0;
        wait_cyc(6);
        rd_check("both flags", EIMC_ADDR_CMP1_CTRL, 8'hB0);
        i_core.sfr_write(EIMC_ADDR_CMP1_CTRL, 8'hC0);
        wait_cyc(3);
        rd_check("flags cleared", EIMC_ADDR_CMP1_CTRL, 8'h80);
        check("cmp1 irq cleared", irq_seen, 8'h00);
        i_core.sfr_write(EIMC_ADDR_CMP1_CTRL, 8'h00);
        wait_cyc(3);
        check("cmp off", {7'h00, cmp_on}, 8'h00);
        cmp_raw = 1'b1;
        wait_cyc(6);
        rd_check("off ignores edge", EIMC_ADDR_CMP1_CTRL, 8'h00);
        check("off no irq", irq_seen, 8'h00);
        cmp_raw = 1'b0;
    endtask

    task automatic test_hyst();
        logic [7:0] v;
        for (int h = 0; h < 4; h++) begin
            v = 8'((h << 2) | (3 - h));
            i_core.sfr_write(EIMC_ADDR_CMP1_CTRL, v);
            wait_cyc(3);
            check("positive hysteresis", {6'h00, hyp}, 8'(h));
            check("negative hysteresis", {6'h00, hyn}, 8'(3 - h));
            rd_check("hysteresis readback", EIMC_ADDR_CMP1_CTRL, v);
        end
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge i_clk);
        #1;
        i_resetn = 1'b1;
        test_reset();
        test_masks();
        test_cmp();
        test_hyst();
        final_report();
    end

    // The whole run takes well under a thousand cycles
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
endmodule
